// [lpst_sleep_timer.sv]
/*
  Sleep timer: 16-bit sleep counter with compare and expiry interrupt,
  12-bit periodic measurement trigger counter for the power manager,
  and the byte registers that configure both and observe the sleep counter.
  Assumes a byte register port that is synchronous to clk_sys, and
  power state signals that come from the power manager.
*/
`timescale 1ns/1ps
`default_nettype none
module lpst_sleep_timer #(
  parameter int unsigned PRESCALE = lpst_pkg::PRESCALE_DIV
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Low-power oscillator clock, sampled as data
  input wire logic lpOscClk,
  // Power manager state
  input wire logic lowPowerActive,
  input wire logic enterPowerDown,
  input wire logic discreteMeasEnable,
  // Interrupt enable mask bit 1
  input wire logic sleepIrqEnable,
  // Byte register port
  input wire logic [lpst_pkg::ADDR_W-1:0] regAddr,
  input wire logic [lpst_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [lpst_pkg::DATA_W-1:0] regRdData,
  output logic regRdValid,
  // Events and status
  output logic sleepExpiryIrq,
  output logic wakeRequest,
  output logic measurementTriggerStrobe,
  output logic elapsedValidFlag,
  output logic sleepTimerRunning
);
  import lpst_pkg::*;

  lpst_state_t state;
  logic tick;
  logic clearAll;
  logic prescaleEnable;
  logic [SLEEP_W-1:0] sleepCount;
  logic [SLEEP_W-1:0] sleepCompareValue;
  logic [SLEEP_W-1:0] adcTriggerCompare;
  logic [TRIG_W-1:0] trigCount;
  logic [TRIG_W-1:0] trigCompare;
  logic sleepMatch;
  logic expireNow;
  logic wakeNow;
  logic wakeLatched;
  logic trigEnable;
  logic trigMatch;

  // ==========================================================
  // Decode of shared conditions
  assign clearAll = enterPowerDown && (state == ST_IDLE);
  assign prescaleEnable = lowPowerActive;
  assign sleepMatch = (sleepCount == sleepCompareValue);
  assign expireNow = (state == ST_RUN) && lowPowerActive && tick && sleepMatch;
  assign wakeNow = expireNow && sleepIrqEnable;
  assign trigCompare = adcTriggerCompare[TRIG_W-1:0];
  assign trigEnable = lowPowerActive && discreteMeasEnable && !wakeLatched;
  assign trigMatch = (trigCount == trigCompare);

  // ==========================================================
  // Prescaler
  lpst_prescaler #(
    .DIV(PRESCALE)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(clearAll),
    .enable(prescaleEnable),
    .lpOscClk(lpOscClk),
    .tick(tick)
  );

  // ==========================================================
  // Sleep timer state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (clearAll) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!lowPowerActive) begin
            state <= ST_IDLE;
          end else if (expireNow) begin
            state <= ST_EXPIRED;
          end
        end
        ST_EXPIRED: begin
          if (!lowPowerActive) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Sleep counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleepCount <= '0;
    end else if (clearAll) begin
      sleepCount <= '0;
    end else if ((state == ST_RUN) && lowPowerActive && tick && !sleepMatch) begin
      sleepCount <= sleepCount + 1'b1;
    end
  end

  // ==========================================================
  // Expiry events
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleepExpiryIrq <= 1'b0;
      wakeRequest <= 1'b0;
    end else begin
      sleepExpiryIrq <= expireNow;
      wakeRequest <= wakeNow;
    end
  end

  // Blocks further strobes once a wake-up is under way
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wakeLatched <= 1'b0;
    end else if (!lowPowerActive || clearAll) begin
      wakeLatched <= 1'b0;
    end else if (wakeNow) begin
      wakeLatched <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleepTimerRunning <= 1'b0;
    end else begin
      sleepTimerRunning <= (state == ST_RUN) || clearAll;
    end
  end

  // Elapsed count becomes meaningful once a power-down has started
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      elapsedValidFlag <= 1'b0;
    end else if (clearAll) begin
      elapsedValidFlag <= 1'b1;
    end
  end

  // ==========================================================
  // Measurement trigger counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trigCount <= '0;
    end else if (clearAll) begin
      trigCount <= '0;
    end else if (trigEnable && tick && !wakeNow) begin
      if (trigMatch) begin
        trigCount <= '0;
      end else begin
        trigCount <= trigCount + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      measurementTriggerStrobe <= 1'b0;
    end else begin
      measurementTriggerStrobe <= trigEnable && tick && trigMatch && !wakeNow;
    end
  end

  // ==========================================================
  // Compare registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      adcTriggerCompare <= {RST_CMP_BYTE, RST_CMP_BYTE};
      sleepCompareValue <= {RST_CMP_BYTE, RST_CMP_BYTE};
    end else if (regWrEn) begin
      unique case (regAddr)
        ADDR_ADC_CMP_LO: adcTriggerCompare[7:0] <= regWrData;
        ADDR_ADC_CMP_HI: adcTriggerCompare[15:8] <= regWrData;
        ADDR_SLEEP_CMP_LO: sleepCompareValue[7:0] <= regWrData;
        ADDR_SLEEP_CMP_HI: sleepCompareValue[15:8] <= regWrData;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Register read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdData <= RD_UNMAPPED;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        unique case (regAddr)
          ADDR_ELAPSED_LO: regRdData <= sleepCount[7:0];
          ADDR_ELAPSED_HI: regRdData <= sleepCount[15:8];
          ADDR_ADC_CMP_LO: regRdData <= adcTriggerCompare[7:0];
          ADDR_ADC_CMP_HI: regRdData <= adcTriggerCompare[15:8];
          ADDR_SLEEP_CMP_LO: regRdData <= sleepCompareValue[7:0];
          ADDR_SLEEP_CMP_HI: regRdData <= sleepCompareValue[15:8];
          default: regRdData <= RD_UNMAPPED;
        endcase
      end
    end
  end

  // ==========================================================
  // Assertions

  // Ticks since the last entry, for the expiry length check
  logic [SLEEP_W:0] ticksSinceEntry;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ticksSinceEntry <= '0;
    end else if (clearAll) begin
      ticksSinceEntry <= '0;
    end else if ((state == ST_RUN) && lowPowerActive && tick) begin
      ticksSinceEntry <= ticksSinceEntry + 1'b1;
    end
  end

  a_full_power_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (!lowPowerActive && !enterPowerDown) |=> $stable(sleepCount) && !measurementTriggerStrobe)
    else $error("sleep counter moved in full power");

  a_entry_clears_all: assert property (@(posedge clk_sys) disable iff (rst)
    clearAll |=> (sleepCount == '0) && (trigCount == '0) && (state == ST_RUN))
    else $error("power-down entry did not clear counters");

  a_sleep_increment: assert property (@(posedge clk_sys) disable iff (rst)
    ((state == ST_RUN) && lowPowerActive && tick && !sleepMatch && !enterPowerDown)
      |=> sleepCount == $past(sleepCount) + 16'h0001)
    else $error("sleep counter failed to increment on tick");

  a_expiry_stops: assert property (@(posedge clk_sys) disable iff (rst)
    expireNow |=> sleepExpiryIrq && (state == ST_EXPIRED) ##1 !sleepExpiryIrq)
    else $error("sleep expiry did not stop and raise one pulse");

  a_expired_holds: assert property (@(posedge clk_sys) disable iff (rst)
    ((state == ST_EXPIRED) && !enterPowerDown) |=> $stable(sleepCount))
    else $error("sleep counter moved after expiry");

  a_wake_masked: assert property (@(posedge clk_sys) disable iff (rst)
    sleepExpiryIrq |-> (wakeRequest == $past(sleepIrqEnable)))
    else $error("wake request disagrees with enable bit");

  a_trigger_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    (trigEnable && tick && trigMatch && !wakeNow && !clearAll)
      |=> measurementTriggerStrobe && (trigCount == '0))
    else $error("trigger match did not strobe and wrap");

  a_wake_priority: assert property (@(posedge clk_sys) disable iff (rst)
    wakeRequest |-> !measurementTriggerStrobe ##1 !measurementTriggerStrobe)
    else $error("trigger strobe issued during wake-up");

  a_elapsed_read: assert property (@(posedge clk_sys) disable iff (rst)
    (regRdEn && regAddr == ADDR_ELAPSED_LO) |=> regRdValid && (regRdData == $past(sleepCount[7:0])))
    else $error("elapsed count read mismatch");

  a_tick_low_power: assert property (@(posedge clk_sys) disable iff (rst)
    !lowPowerActive |=> !tick)
    else $error("prescaler ticked in full power");

  a_run_flag: assert property (@(posedge clk_sys) disable iff (rst)
    clearAll |=> sleepTimerRunning)
    else $error("sleep timer not running after power-down entry");

  a_expiry_length: assert property (@(posedge clk_sys) disable iff (rst)
    sleepExpiryIrq |-> (ticksSinceEntry == ({1'b0, sleepCount} + 17'h00001)))
    else $error("sleep expiry came after the wrong number of ticks");

  a_trigger_gated: assert property (@(posedge clk_sys) disable iff (rst)
    (!trigEnable && !clearAll) |=> $stable(trigCount) && !measurementTriggerStrobe)
    else $error("trigger counter moved while disabled");

  a_trigger_step: assert property (@(posedge clk_sys) disable iff (rst)
    (trigEnable && tick && !trigMatch && !wakeNow && !clearAll)
      |=> trigCount == $past(trigCount) + 12'h001)
    else $error("trigger counter failed to step on tick");

  a_elapsed_valid: assert property (@(posedge clk_sys) disable iff (rst)
    (clearAll || elapsedValidFlag) |=> elapsedValidFlag)
    else $error("elapsed valid flag not set or lost");

  a_adc_cmp_low: assert property (@(posedge clk_sys) disable iff (rst)
    (regWrEn && regAddr == ADDR_ADC_CMP_LO) |=> adcTriggerCompare[7:0] == $past(regWrData))
    else $error("trigger compare low byte write lost");

  a_adc_cmp_high: assert property (@(posedge clk_sys) disable iff (rst)
    (regWrEn && regAddr == ADDR_ADC_CMP_HI) |=> adcTriggerCompare[15:8] == $past(regWrData))
    else $error("trigger compare high byte write lost");

  a_sleep_cmp_low: assert property (@(posedge clk_sys) disable iff (rst)
    (regWrEn && regAddr == ADDR_SLEEP_CMP_LO) |=> sleepCompareValue[7:0] == $past(regWrData))
    else $error("sleep compare low byte write lost");

  a_sleep_cmp_high: assert property (@(posedge clk_sys) disable iff (rst)
    (regWrEn && regAddr == ADDR_SLEEP_CMP_HI) |=> sleepCompareValue[15:8] == $past(regWrData))
    else $error("sleep compare high byte write lost");

  c_sleep_expiry: cover property (@(posedge clk_sys) disable iff (rst) sleepExpiryIrq);
  c_masked_expiry: cover property (@(posedge clk_sys) disable iff (rst)
    sleepExpiryIrq && !wakeRequest);
  c_trigger_strobe: cover property (@(posedge clk_sys) disable iff (rst) measurementTriggerStrobe);
  c_wake_blocks_trigger: cover property (@(posedge clk_sys) disable iff (rst)
    wakeNow && trigEnable && trigMatch);
  c_return_mid_count: cover property (@(posedge clk_sys) disable iff (rst)
    (state == ST_RUN) && !lowPowerActive);

endmodule
`default_nettype wire

// [lpst_pkg.sv]
/*
  Package for the low-power sleep and ADC trigger timer.
  Holds register offsets, reset values, widths and timing constants.
  Assumes nothing of its surroundings.
*/
package lpst_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned LP_CLK_HZ = 125000;
  localparam int unsigned TICK_HZ = 10;
  localparam int unsigned TICK_PERIOD_MS = 100;
  localparam int unsigned PRESCALE_DIV = LP_CLK_HZ / TICK_HZ;
  localparam int unsigned SYS_CLK_HZ = 10000000;
  localparam int unsigned SYS_PER_LP = SYS_CLK_HZ / LP_CLK_HZ;

  // ==========================================================
  // Widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SLEEP_W = 16;
  localparam int unsigned TRIG_W = 12;
  localparam int unsigned DIV_W = 14;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_ELAPSED_LO = 8'h20;
  localparam logic [7:0] ADDR_ELAPSED_HI = 8'h21;
  localparam logic [7:0] ADDR_ADC_CMP_LO = 8'h60;
  localparam logic [7:0] ADDR_ADC_CMP_HI = 8'h61;
  localparam logic [7:0] ADDR_SLEEP_CMP_LO = 8'h62;
  localparam logic [7:0] ADDR_SLEEP_CMP_HI = 8'h63;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CMP_BYTE = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ==========================================================
  // Sleep timer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_EXPIRED = 3'b100
  } lpst_state_t;

endpackage

// [lpst_prescaler.sv]
/*
  Fixed prescaler of the sleep timer: counts rising edges of the
  low-power oscillator clock and emits one tick every DIV edges.
  Assumes lpOscClk is synchronous to clk_sys and much slower than it.
*/
`timescale 1ns/1ps
`default_nettype none
module lpst_prescaler #(
  parameter int unsigned DIV = lpst_pkg::PRESCALE_DIV
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic enable,
  // Low-power oscillator clock, sampled as data
  input wire logic lpOscClk,
  // Tick out
  output logic tick
);
  import lpst_pkg::*;

  logic lpPrev;
  logic lpEdge;
  logic [DIV_W-1:0] divCount;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

  assign lpEdge = lpOscClk && !lpPrev;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lpPrev <= 1'b0;
    end else begin
      lpPrev <= lpOscClk;
    end
  end

  // ==========================================================
  // Divide by DIV
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      divCount <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (clear) begin
        divCount <= '0;
      end else if (enable && lpEdge) begin
        if (divCount == DIV_LAST) begin
          divCount <= '0;
          tick <= 1'b1;
        end else begin
          divCount <= divCount + 1'b1;
        end
      end
    end
  end

  a_tick_division: assert property (@(posedge clk_sys) disable iff (rst)
    (enable && !clear && lpEdge && divCount == DIV_LAST) |=> tick)
    else $error("prescaler tick missing after last edge");

endmodule
`default_nettype wire

// [lpst_power_model.sv]
/*
  Behavioural power manager and low-power oscillator facing the sleep timer.
  Assumes clk_sys at 10 MHz; the oscillator runs free at one eighth of it.
*/
`timescale 1ns/1ps
`default_nettype none
module lpst_power_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bench request and timer events
  input wire logic sleepReq,
  input wire logic wakeRequest,
  input wire logic measurementTriggerStrobe,
  // Drives to the timer
  output logic lpOscClk,
  output logic lowPowerActive,
  output logic enterPowerDown,
  // Observation
  output logic [15:0] edgeCount,
  output logic [7:0] strobeCount
);
  logic [2:0] div;
  logic lpPrev;
  logic woke;

  // ==========================================================
  // Oscillator
  assign lpOscClk = div[2];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div <= 3'h0;
      lpPrev <= 1'b0;
    end else begin
      div <= div + 3'h1;
      lpPrev <= lpOscClk;
    end
  end

  // ==========================================================
  // Power state: entry only mid-low of the oscillator, so no edge is ambiguous
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lowPowerActive <= 1'b0;
      enterPowerDown <= 1'b0;
      woke <= 1'b0;
    end else begin
      enterPowerDown <= 1'b0;
      if (!sleepReq) begin
        lowPowerActive <= 1'b0;
        woke <= 1'b0;
      end else if (wakeRequest) begin
        lowPowerActive <= 1'b0;
        woke <= 1'b1;
      end else if (!lowPowerActive && !woke && div == 3'h1) begin
        lowPowerActive <= 1'b1;
        enterPowerDown <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Edges counted in power-down and strobes received since entry
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      edgeCount <= 16'h0;
      strobeCount <= 8'h0;
    end else if (enterPowerDown) begin
      edgeCount <= 16'h0;
      strobeCount <= 8'h0;
    end else begin
      if (lowPowerActive && lpOscClk && !lpPrev) begin
        edgeCount <= edgeCount + 16'h1;
      end
      if (measurementTriggerStrobe) begin
        strobeCount <= strobeCount + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [lpst_sleep_timer_tb.sv]
/*
  Self-checking bench for the sleep timer: register tasks and timed scenarios.
  Assumes the power model file; prescaler shortened to four oscillator edges.
*/
`timescale 1ns/1ps
`default_nettype none
module lpst_sleep_timer_tb;
  import lpst_pkg::*;
  localparam int unsigned PRE = 4;
  logic clk_sys, rst, lpOscClk, lowPowerActive, enterPowerDown, sleepReq;
  logic discreteMeasEnable, sleepIrqEnable, regWrEn, regRdEn, regRdValid;
  logic [7:0] regAddr, regWrData, regRdData, strobeCount;
  logic sleepExpiryIrq, wakeRequest, measurementTriggerStrobe, elapsedValidFlag;
  logic sleepTimerRunning;
  logic [15:0] edgeCount;
  int n_errors = 0;
  int comparisons = 0;

  // ==========================================================
  // Instances
  lpst_sleep_timer #(.PRESCALE(PRE)) u_lpst_sleep_timer (.clk_sys(clk_sys), .rst(rst),
    .lpOscClk(lpOscClk), .lowPowerActive(lowPowerActive), .enterPowerDown(enterPowerDown),
    .discreteMeasEnable(discreteMeasEnable), .sleepIrqEnable(sleepIrqEnable),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdValid(regRdValid), .sleepExpiryIrq(sleepExpiryIrq),
    .wakeRequest(wakeRequest), .measurementTriggerStrobe(measurementTriggerStrobe),
    .elapsedValidFlag(elapsedValidFlag), .sleepTimerRunning(sleepTimerRunning));
  lpst_power_model u_lpst_power_model (.clk_sys(clk_sys), .rst(rst), .sleepReq(sleepReq),
    .wakeRequest(wakeRequest), .measurementTriggerStrobe(measurementTriggerStrobe),
    .lpOscClk(lpOscClk), .lowPowerActive(lowPowerActive), .enterPowerDown(enterPowerDown),
    .edgeCount(edgeCount), .strobeCount(strobeCount));

  // ==========================================================
  // Tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  task automatic readCheck(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    check({15'h0, regRdValid}, 16'h1);
    check({8'h0, regRdData}, {8'h0, exp});
  endtask
  task automatic setup(input logic [15:0] sc, input logic [15:0] ac, input logic ie,
                       input logic de);
    regWrite(ADDR_SLEEP_CMP_LO, sc[7:0]);
    regWrite(ADDR_SLEEP_CMP_HI, sc[15:8]);
    regWrite(ADDR_ADC_CMP_LO, ac[7:0]);
    regWrite(ADDR_ADC_CMP_HI, ac[15:8]);
    sleepIrqEnable <= ie;
    discreteMeasEnable <= de;
    sleepReq <= 1'b1;
    do begin
      @(posedge clk_sys);
      #1;
    end while (lowPowerActive !== 1'b1);
    @(posedge clk_sys);
    #1;
  endtask
  function automatic logic pick(input int sel);
    return (sel != 0) ? measurementTriggerStrobe : sleepExpiryIrq;
  endfunction
  task automatic waitSig(input int sel);
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      #1;
      i++;
    end while (pick(sel) !== 1'b1 && i < 3000);
    check({15'h0, pick(sel)}, 16'h1);
  endtask
  task automatic leave(input string name);
    sleepReq <= 1'b0;
    repeat (10) @(posedge clk_sys);
    $display("Test %s finished", name);
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #2000000;
    n_errors++;
    tally_and_finish();
  end

  // ==========================================================
  // Tests
  initial begin
    rst = 1'b1;
    sleepReq = 1'b0;
    discreteMeasEnable = 1'b0;
    sleepIrqEnable = 1'b0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, read-only and unmapped places
    for (int k = 0; k < 4; k++) readCheck(ADDR_ADC_CMP_LO + 8'(k), RST_CMP_BYTE);
    readCheck(ADDR_ELAPSED_HI, 8'h00);
    check({15'h0, elapsedValidFlag}, 16'h0);
    regWrite(ADDR_ELAPSED_LO, 8'hff);
    readCheck(ADDR_ELAPSED_LO, 8'h00);
    readCheck(8'h55, RD_UNMAPPED);
    for (int k = 0; k < 4; k++) regWrite(ADDR_ADC_CMP_LO + 8'(k), 8'ha1 + 8'(k));
    for (int k = 0; k < 4; k++) readCheck(ADDR_ADC_CMP_LO + 8'(k), 8'ha1 + 8'(k));
    leave("registers");
    // Waking expiry, measurement counter off
    setup(16'h0002, 16'h0000, 1'b1, 1'b0);
    check({15'h0, sleepTimerRunning}, 16'h1);
    check({15'h0, elapsedValidFlag}, 16'h1);
    waitSig(0);
    check(edgeCount, 16'(PRE * 3));
    check({15'h0, wakeRequest}, 16'h1);
    readCheck(ADDR_ELAPSED_LO, 8'h02);
    check({15'h0, sleepTimerRunning}, 16'h0);
    check({8'h0, strobeCount}, 16'h0);
    leave("waking expiry");
    // Silent expiry, trigger period from low twelve bits only
    setup(16'h0002, 16'hf001, 1'b0, 1'b1);
    readCheck(ADDR_ELAPSED_LO, 8'h00);
    for (int k = 1; k <= 4; k++) begin
      waitSig(1);
      check(edgeCount, 16'(PRE * 2 * k));
      if (k == 1) begin
        waitSig(0);
        check({15'h0, wakeRequest}, 16'h0);
      end
    end
    check({15'h0, lowPowerActive}, 16'h1);
    check({15'h0, sleepTimerRunning}, 16'h0);
    readCheck(ADDR_ELAPSED_LO, 8'h02);
    leave("silent expiry");
    // Return to full power mid-count
    setup(16'h0100, 16'h0000, 1'b1, 1'b1);
    for (int i = 0; i < 3000 && edgeCount != 16'(PRE * 5); i++) begin
      @(posedge clk_sys);
      #1;
    end
    repeat (4) @(posedge clk_sys);
    sleepReq <= 1'b0;
    repeat (60) @(posedge clk_sys);
    check({8'h0, strobeCount}, 16'h5);
    readCheck(ADDR_ELAPSED_LO, 8'h05);
    readCheck(ADDR_ELAPSED_HI, 8'h00);
    check({15'h0, sleepTimerRunning}, 16'h0);
    leave("full power return");
    // Wake and trigger on the same tick
    setup(16'h0001, 16'h0001, 1'b1, 1'b1);
    waitSig(0);
    check({15'h0, wakeRequest}, 16'h1);
    repeat (40) @(posedge clk_sys);
    check({8'h0, strobeCount}, 16'h0);
    leave("wake priority");
    tally_and_finish();
  end
endmodule
`default_nettype wire
